// ### verif/drosc_host.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// host controller behind the serial decoder
// ****************************************************************
module drosc_host (
  // clock
  input  wire logic                         core_clk,
  // register port
  output logic                              reg_wr_en = 1'b0,
  output logic                              reg_rd_en = 1'b0,
  output logic [drosc_pkg::REG_AW-1:0]      reg_addr = 8'h00,
  output logic [drosc_pkg::REG_DW-1:0]      reg_wdata = 8'hFF
);
  import drosc_pkg::*;
  // one access; idle lines show the inverse so stale values never match
  task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr_en <= w;
    reg_rd_en <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr_en <= 1'b0;
    reg_rd_en <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // offset update: three halves first, low A word last to fire autosync
  task automatic ofs(input logic [12:0] oa, input logic [12:0] ob, input logic [2:0] ctl);
    acc(1'b1, 1'b0, CHAN_B_OFFSET_LOW_ADDR, ob[7:0]);
    acc(1'b1, 1'b0, CHAN_A_OFFSET_HIGH_ADDR, {oa[12:8], 3'h0});
    acc(1'b1, 1'b0, CHAN_B_OFFSET_HIGH_SS_ADDR, {ob[12:8], ctl});
    repeat (4) @(posedge core_clk);
    acc(1'b1, 1'b0, CHAN_A_OFFSET_LOW_ADDR, oa[7:0]);
  endtask
endmodule
`default_nettype wire

// ### verif/drosc_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// port checker for the register slice
// ****************************************************************
module drosc_top_asserts (
  // clock and reset
  input wire logic                         core_clk,
  input wire logic                         rst,
  // register writes
  input wire logic                         reg_wr_en,
  input wire logic [drosc_pkg::REG_AW-1:0] reg_addr,
  input wire logic [drosc_pkg::REG_DW-1:0] reg_wdata,
  // sync and static controls
  input wire logic                         external_sync_strobe,
  input wire logic                         frame_fifo_marker,
  input wire logic                         clkdiv_sync_enable,
  input wire logic                         multi_sync_pulse,
  input wire logic                         clkdiv_sync_pulse,
  input wire logic                         offset_autosync,
  input wire logic                         four_pin_serial_select,
  input wire logic                         clkpath_en_a,
  input wire logic                         clkpath_en_b
);
  import drosc_pkg::*;
  logic       sel_r;
  logic [2:0] ctl_r;
  logic       src;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // shadow of the select bit and the low control bits of 0x17
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sel_r <= 1'b0;
      ctl_r <= 3'h0;
    end else if (reg_wr_en && reg_addr == ROUTING_SYNC_SELECT_ADDR) begin
      sel_r <= reg_wdata[SYNC_SRC_SEL_BIT];
    end else if (reg_wr_en && reg_addr == CHAN_B_OFFSET_HIGH_SS_ADDR) begin
      ctl_r <= reg_wdata[2:0];
    end
  end
  assign src = sel_r ? frame_fifo_marker : external_sync_strobe;
  // $past guards keep values from inside reset out of the checks
  AST_SYNC_SRC: assert property (!$past(rst) |-> multi_sync_pulse == $past(src))
    else $error("multi sync pulse does not follow selected source");
  AST_DIV_SYNC: assert property (!$past(rst) |->
    clkdiv_sync_pulse == $past(src && clkdiv_sync_enable))
    else $error("divider sync pulse wrong");
  AST_AUTOSYNC_ON: assert property (reg_wr_en && reg_addr == CHAN_A_OFFSET_LOW_ADDR
    |=> offset_autosync) else $error("no autosync after low A write");
  AST_AUTOSYNC_CAUSE: assert property (!$past(rst) && offset_autosync |->
    $past(reg_wr_en) && $past(reg_addr) == CHAN_A_OFFSET_LOW_ADDR)
    else $error("autosync without low A write");
  AST_NO_AUTOSYNC: assert property (reg_wr_en && reg_addr inside {[8'h15:8'h17]}
    |=> !offset_autosync) else $error("autosync on other offset write");
  AST_FOUR_PIN: assert property (!$past(rst) |->
    four_pin_serial_select == $past(ctl_r[FOUR_PIN_SERIAL_BIT]))
    else $error("four pin select wrong");
  AST_SLEEP_A: assert property (!$past(rst) |->
    clkpath_en_a == !$past(ctl_r[CLKPATH_SLEEP_A_BIT])) else $error("clock path A wrong");
  AST_SLEEP_B: assert property (!$past(rst) |->
    clkpath_en_b == !$past(ctl_r[CLKPATH_SLEEP_B_BIT])) else $error("clock path B wrong");
endmodule
bind drosc_top drosc_top_asserts drosc_top_asserts_i (.core_clk, .rst, .reg_wr_en,
  .reg_addr, .reg_wdata, .external_sync_strobe, .frame_fifo_marker, .clkdiv_sync_enable,
  .multi_sync_pulse, .clkdiv_sync_pulse, .offset_autosync, .four_pin_serial_select,
  .clkpath_en_a, .clkpath_en_b);
`default_nettype wire

// ### verif/dual_dac_route_offset_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dual_dac_route_offset_config_tb;
  import drosc_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, reg_wr_en, reg_rd_en, reg_rvalid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, sh [5], v, rd, rq [$];
  logic [15:0] chan_a_data = 16'h0000, chan_b_data = 16'h0000, dac_a_data, dac_b_data, la, lb;
  logic strobe = 1'b0, frame = 1'b0, div_en = 1'b0, en_a, en_b;
  logic [12:0] oa, ob;
  logic msy, dsy, asy, fps, cpa, cpb;
  logic [38:0] ex, dq [$];
  int n_tests = 0, num_errors = 0;
  initial forever #2.5 core_clk = ~core_clk;
  drosc_host drosc_host_i (.core_clk(core_clk), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  drosc_top drosc_top_i (.core_clk(core_clk), .rst(rst), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .chan_a_data(chan_a_data),
    .chan_b_data(chan_b_data), .dac_a_data(dac_a_data), .dac_b_data(dac_b_data),
    .external_sync_strobe(strobe), .frame_fifo_marker(frame), .clkdiv_sync_enable(div_en),
    .multi_sync_pulse(msy), .clkdiv_sync_pulse(dsy), .offset_autosync(asy),
    .four_pin_serial_select(fps), .clkpath_en_a(cpa), .clkpath_en_b(cpb));
  // fresh samples and sync inputs every cycle
  always @(posedge core_clk) begin
    chan_a_data <= 16'($urandom);
    chan_b_data <= 16'($urandom);
    {strobe, frame, div_en} <= 3'($urandom);
  end
  // reference model: outputs from pre-edge state, then state update
  always @(posedge core_clk) begin
    logic [15:0] ra, rb, xa, xb;
    logic        s;
    if (rst) begin
      foreach (sh[i]) sh[i] = 8'h00;
      {oa, ob, la, lb, en_a, en_b} = {58'h0, 2'b11};
    end else begin
      for (int i = 0; i < 16; i++) begin
        ra[i] = sh[0][0] ? chan_a_data[15-i] : chan_a_data[i];
        rb[i] = sh[0][0] ? chan_b_data[15-i] : chan_b_data[i];
      end
      xa = (!sh[0][7] && sh[0][6]) ? rb : ra;
      xb = sh[0][7] ? ra : rb;
      if (en_a) la = xa + {{3{oa[12]}}, oa};
      if (en_b) lb = xb + {{3{ob[12]}}, ob};
      if (reg_rd_en) rq.push_back(reg_addr inside {[8'h13:8'h17]} ? sh[reg_addr-8'h13] : 8'h00);
      {en_a, en_b} = ~sh[4][1:0];
      s = sh[0][1] ? frame : strobe;
      dq.push_back({la, lb, s, s & div_en, reg_wr_en && reg_addr == CHAN_A_OFFSET_LOW_ADDR,
                    sh[4][2], en_a, en_b, reg_rd_en});
      if (reg_wr_en && reg_addr inside {[8'h13:8'h17]}) begin
        if (reg_addr == CHAN_A_OFFSET_LOW_ADDR) begin
          {oa, ob} = {sh[3][7:3], reg_wdata, sh[4][7:3], sh[2]};
        end
        sh[reg_addr-8'h13] = reg_wdata;
      end
    end
  end
  task automatic cmp16(input string n, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic cmp7(input string n, input logic [6:0] e, input logic [6:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %b got %b", n, e, g);
    end
  endtask
  task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // watcher: oldest note against what the outputs show
  always @(negedge core_clk) begin
    if (!rst && dq.size() > 0) begin
      ex = dq.pop_front();
      cmp16("dac_a_data", ex[38:23], dac_a_data);
      cmp16("dac_b_data", ex[22:7], dac_b_data);
      cmp7("sync_autosync_serial_clkpath_rvalid", ex[6:0],
           {msy, dsy, asy, fps, cpa, cpb, reg_rvalid});
    end
    if (reg_rvalid === 1'b1) begin
      rd = (rq.size() > 0) ? rq.pop_front() : 8'hXX;
      cmp8("reg_rdata", rd, reg_rdata);
    end
  end
  task automatic results();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h82CCA3DC));
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    // reset values, unmapped neighbours included
    for (int a = 8'h12; a <= 8'h18; a++) drosc_host_i.acc(1'b0, 1'b1, 8'(a), 8'h00);
    // every bit read back; unmapped writes vanish
    for (int a = 8'h12; a <= 8'h18; a++) begin
      v = 8'($urandom);
      drosc_host_i.acc(1'b1, 1'b0, 8'(a), v);
      drosc_host_i.acc(1'b0, 1'b1, 8'(a), 8'h00);
    end
    // read with write to the same place returns the old value
    drosc_host_i.acc(1'b1, 1'b1, ROUTING_SYNC_SELECT_ADDR, 8'h00);
    drosc_host_i.acc(1'b1, 1'b0, CHAN_B_OFFSET_HIGH_SS_ADDR, 8'h00);
    // every copy, bit order and sync source combination
    for (int m = 0; m < 16; m++) begin
      v = {m[3:2], 4'h0, m[1:0]};
      drosc_host_i.acc(1'b1, 1'b0, ROUTING_SYNC_SELECT_ADDR, v);
      repeat (6) @(posedge core_clk);
    end
    // extreme offsets, then random ones with every sleep pattern
    drosc_host_i.ofs(13'h1000, 13'h0FFF, 3'h0);
    for (int k = 0; k < 8; k++) begin
      drosc_host_i.ofs(13'($urandom), 13'($urandom), k[2:0]);
      repeat (6) @(posedge core_clk);
    end
    for (int t = 0; t < 20 && rq.size() > 0; t++) @(posedge core_clk);
    if (rq.size() > 0) num_errors++;
    results();
  end
endmodule
`default_nettype wire

// ### verilog/drosc_lane.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// one channel: offset correction added in converter lsbs
// ****************************************************************
module drosc_lane (
  // routed sample in
  input  wire logic [drosc_pkg::DATA_W-1:0] lane_data_in,
  // active two's complement offset
  input  wire logic [drosc_pkg::OFS_W-1:0]  lane_offset,
  // corrected sample out
  output logic      [drosc_pkg::DATA_W-1:0] lane_data_out
);
  import drosc_pkg::*;

  logic [DATA_W-1:0] offset_ext;

  // sign extend, then wrap-around add; the sum keeps the sample width
  always_comb begin
    offset_ext    = {{(DATA_W-OFS_W){lane_offset[OFS_W-1]}}, lane_offset};
    lane_data_out = lane_data_in + offset_ext;
  end

endmodule

`default_nettype wire

// ### verilog/drosc_pkg.sv
package drosc_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int unsigned REG_AW     = 8;
  localparam int unsigned REG_DW     = 8;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned OFS_W      = 13;
  localparam int unsigned OFS_LO_W   = 8;
  localparam int unsigned OFS_HI_W   = 5;
  localparam int unsigned NUM_CHAN   = 2;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [REG_AW-1:0] ROUTING_SYNC_SELECT_ADDR    = 8'h13;
  localparam logic [REG_AW-1:0] CHAN_A_OFFSET_LOW_ADDR      = 8'h14;
  localparam logic [REG_AW-1:0] CHAN_B_OFFSET_LOW_ADDR      = 8'h15;
  localparam logic [REG_AW-1:0] CHAN_A_OFFSET_HIGH_ADDR     = 8'h16;
  localparam logic [REG_AW-1:0] CHAN_B_OFFSET_HIGH_SS_ADDR  = 8'h17;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [REG_DW-1:0] ROUTING_SYNC_SELECT_RST     = 8'h00;
  localparam logic [REG_DW-1:0] CHAN_A_OFFSET_LOW_RST       = 8'h00;
  localparam logic [REG_DW-1:0] CHAN_B_OFFSET_LOW_RST       = 8'h00;
  localparam logic [REG_DW-1:0] CHAN_A_OFFSET_HIGH_RST      = 8'h00;
  localparam logic [REG_DW-1:0] CHAN_B_OFFSET_HIGH_SS_RST   = 8'h00;
  localparam logic [REG_DW-1:0] UNMAPPED_READ_VAL           = 8'h00;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned COPY_A_TO_B_BIT     = 7;
  localparam int unsigned COPY_B_TO_A_BIT     = 6;
  localparam int unsigned SYNC_SRC_SEL_BIT    = 1;
  localparam int unsigned BIT_REVERSE_BIT     = 0;
  localparam int unsigned OFS_HI_MSB          = 7;
  localparam int unsigned OFS_HI_LSB          = 3;
  localparam int unsigned FOUR_PIN_SERIAL_BIT = 2;
  localparam int unsigned CLKPATH_SLEEP_A_BIT = 1;
  localparam int unsigned CLKPATH_SLEEP_B_BIT = 0;

  // sync source encodings
  localparam logic SYNC_SRC_STROBE = 1'b0;
  localparam logic SYNC_SRC_FRAME  = 1'b1;

  // channel indices
  localparam int unsigned CHAN_A = 0;
  localparam int unsigned CHAN_B = 1;

endpackage

// ### verilog/drosc_top.sv
`timescale 1ns/1ps
`default_nettype none

module drosc_top (
  // clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          rst,
  // register port from the serial control decoder
  input  wire logic                          reg_wr_en,
  input  wire logic                          reg_rd_en,
  input  wire logic [drosc_pkg::REG_AW-1:0]  reg_addr,
  input  wire logic [drosc_pkg::REG_DW-1:0]  reg_wdata,
  output logic      [drosc_pkg::REG_DW-1:0]  reg_rdata,
  output logic                               reg_rvalid,
  // channel samples in
  input  wire logic [drosc_pkg::DATA_W-1:0]  chan_a_data,
  input  wire logic [drosc_pkg::DATA_W-1:0]  chan_b_data,
  // converter samples out
  output logic      [drosc_pkg::DATA_W-1:0]  dac_a_data,
  output logic      [drosc_pkg::DATA_W-1:0]  dac_b_data,
  // synchronisation
  input  wire logic                          external_sync_strobe,
  input  wire logic                          frame_fifo_marker,
  input  wire logic                          clkdiv_sync_enable,
  output logic                               multi_sync_pulse,
  output logic                               clkdiv_sync_pulse,
  output logic                               offset_autosync,
  // static controls to the rest of the chip
  output logic                               four_pin_serial_select,
  output logic                               clkpath_en_a,
  output logic                               clkpath_en_b
);
  import drosc_pkg::*;

  // ****************************************************************
  // register file
  // ****************************************************************
  // map: 0x13 routing and sync select, 0x14/0x15 low offset bytes,
  // 0x16/0x17 upper offset bits; 0x17 bits 2:0 are serial and sleep
  // controls; every bit of every register is read/write
  logic [REG_DW-1:0] routing_sync_select_r, routing_sync_select_nxt;
  logic [REG_DW-1:0] chan_a_offset_low_r,   chan_a_offset_low_nxt;
  logic [REG_DW-1:0] chan_b_offset_low_r,   chan_b_offset_low_nxt;
  logic [REG_DW-1:0] chan_a_offset_high_r,  chan_a_offset_high_nxt;
  logic [REG_DW-1:0] chan_b_ofs_hi_ss_r,    chan_b_ofs_hi_ss_nxt;
  logic [REG_DW-1:0] reg_rdata_r,           reg_rdata_nxt;
  logic              reg_rvalid_r,          reg_rvalid_nxt;
  logic              autosync_hit;

  // writes store values; only the channel A low write triggers a load
  // unmapped writes fall through the default and change nothing
  always_comb begin
    routing_sync_select_nxt = routing_sync_select_r;
    chan_a_offset_low_nxt   = chan_a_offset_low_r;
    chan_b_offset_low_nxt   = chan_b_offset_low_r;
    chan_a_offset_high_nxt  = chan_a_offset_high_r;
    chan_b_ofs_hi_ss_nxt    = chan_b_ofs_hi_ss_r;
    autosync_hit            = 1'b0;
    if (reg_wr_en) begin
      unique case (reg_addr)
        ROUTING_SYNC_SELECT_ADDR:   routing_sync_select_nxt = reg_wdata;
        CHAN_A_OFFSET_LOW_ADDR: begin
          chan_a_offset_low_nxt = reg_wdata;
          autosync_hit          = 1'b1;
        end
        CHAN_B_OFFSET_LOW_ADDR:     chan_b_offset_low_nxt  = reg_wdata;
        CHAN_A_OFFSET_HIGH_ADDR:    chan_a_offset_high_nxt = reg_wdata;
        CHAN_B_OFFSET_HIGH_SS_ADDR: chan_b_ofs_hi_ss_nxt   = reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // read data, one cycle after the read strobe; holes read as zero
  // rdata holds between reads so a slow decoder can still pick it up
  always_comb begin
    reg_rvalid_nxt = reg_rd_en;
    reg_rdata_nxt  = reg_rdata_r;
    if (reg_rd_en) begin
      unique case (reg_addr)
        ROUTING_SYNC_SELECT_ADDR:   reg_rdata_nxt = routing_sync_select_r;
        CHAN_A_OFFSET_LOW_ADDR:     reg_rdata_nxt = chan_a_offset_low_r;
        CHAN_B_OFFSET_LOW_ADDR:     reg_rdata_nxt = chan_b_offset_low_r;
        CHAN_A_OFFSET_HIGH_ADDR:    reg_rdata_nxt = chan_a_offset_high_r;
        CHAN_B_OFFSET_HIGH_SS_ADDR: reg_rdata_nxt = chan_b_ofs_hi_ss_r;
        default:                    reg_rdata_nxt = UNMAPPED_READ_VAL;
      endcase
    end
  end

  // register file flops
  // all registers share one synchronous reset, released together
  always_ff @(posedge core_clk) begin
    if (rst) begin
      routing_sync_select_r <= ROUTING_SYNC_SELECT_RST;
      chan_a_offset_low_r   <= CHAN_A_OFFSET_LOW_RST;
      chan_b_offset_low_r   <= CHAN_B_OFFSET_LOW_RST;
      chan_a_offset_high_r  <= CHAN_A_OFFSET_HIGH_RST;
      chan_b_ofs_hi_ss_r    <= CHAN_B_OFFSET_HIGH_SS_RST;
      reg_rdata_r           <= UNMAPPED_READ_VAL;
      reg_rvalid_r          <= 1'b0;
    end else begin
      routing_sync_select_r <= routing_sync_select_nxt;
      chan_a_offset_low_r   <= chan_a_offset_low_nxt;
      chan_b_offset_low_r   <= chan_b_offset_low_nxt;
      chan_a_offset_high_r  <= chan_a_offset_high_nxt;
      chan_b_ofs_hi_ss_r    <= chan_b_ofs_hi_ss_nxt;
      reg_rdata_r           <= reg_rdata_nxt;
      reg_rvalid_r          <= reg_rvalid_nxt;
    end
  end

  assign reg_rdata  = reg_rdata_r;
  assign reg_rvalid = reg_rvalid_r;

  // ****************************************************************
  // active offsets, loaded only by autosync
  // ****************************************************************
  // the stored bytes are only a staging area; the lanes see the active
  // copy, so a half-written offset never reaches the converters
  logic [OFS_W-1:0] act_ofs_a_r, act_ofs_a_nxt;
  logic [OFS_W-1:0] act_ofs_b_r, act_ofs_b_nxt;
  logic             autosync_r,  autosync_nxt;

  // the load takes the incoming low byte of A plus the three stored bytes,
  // so a single write both stores and applies in the same edge
  always_comb begin
    act_ofs_a_nxt = act_ofs_a_r;
    act_ofs_b_nxt = act_ofs_b_r;
    autosync_nxt  = autosync_hit;
    if (autosync_hit) begin
      act_ofs_a_nxt = {chan_a_offset_high_r[OFS_HI_MSB:OFS_HI_LSB],
                       chan_a_offset_low_nxt};
      act_ofs_b_nxt = {chan_b_ofs_hi_ss_r[OFS_HI_MSB:OFS_HI_LSB],
                       chan_b_offset_low_r};
    end
  end

  // active offset flops
  // reset clears the active copy too, so no stale offset survives it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      act_ofs_a_r <= '0;
      act_ofs_b_r <= '0;
      autosync_r  <= 1'b0;
    end else begin
      act_ofs_a_r <= act_ofs_a_nxt;
      act_ofs_b_r <= act_ofs_b_nxt;
      autosync_r  <= autosync_nxt;
    end
  end

  // one-cycle strobe telling the rest of the chip the offsets changed
  assign offset_autosync = autosync_r;

  // ****************************************************************
  // data path: reverse, route, correct
  // ****************************************************************
  // order is fixed: mirror first, then route, then offset; one register
  // stage from sample in to converter out keeps both channels aligned
  logic [DATA_W-1:0] rev_a, rev_b;
  logic [DATA_W-1:0] route_a, route_b;
  // lane arrays let one generate loop serve both channels
  logic [DATA_W-1:0] lane_in  [NUM_CHAN];
  logic [DATA_W-1:0] lane_out [NUM_CHAN];
  logic [OFS_W-1:0]  lane_ofs [NUM_CHAN];
  logic [DATA_W-1:0] dac_a_r, dac_a_nxt;
  logic [DATA_W-1:0] dac_b_r, dac_b_nxt;
  logic              copy_a2b, copy_b2a, bit_rev;

  assign copy_a2b = routing_sync_select_r[COPY_A_TO_B_BIT];
  assign copy_b2a = routing_sync_select_r[COPY_B_TO_A_BIT];
  assign bit_rev  = routing_sync_select_r[BIT_REVERSE_BIT];

  // bit mirror of each input word
  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++) begin : g_rev
      assign rev_a[gi] = bit_rev ? chan_a_data[DATA_W-1-gi] : chan_a_data[gi];
      assign rev_b[gi] = bit_rev ? chan_b_data[DATA_W-1-gi] : chan_b_data[gi];
    end
  endgenerate

  // routing; copy-A-to-B checked first so A keeps its own data when both set
  always_comb begin
    route_a = rev_a;
    route_b = rev_b;
    if (copy_a2b) begin
      route_b = rev_a;
    end else if (copy_b2a) begin
      route_a = rev_b;
    end
  end

  assign lane_in[CHAN_A]  = route_a;
  assign lane_in[CHAN_B]  = route_b;
  assign lane_ofs[CHAN_A] = act_ofs_a_r;
  assign lane_ofs[CHAN_B] = act_ofs_b_r;

  // one offset adder per channel
  // routing happens before the adders, so each adds the offset of the
  // converter it feeds, not that of the source channel
  generate
    for (gi = 0; gi < NUM_CHAN; gi++) begin : g_lane
      drosc_lane drosc_lane_i (
        .lane_data_in  (lane_in[gi]),
        .lane_offset   (lane_ofs[gi]),
        .lane_data_out (lane_out[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // clock-path gating and static controls
  // ****************************************************************
  // the gate itself sits outside this slice; here it is an enable out
  // plus a frozen output, which is what the converter would see
  logic clkpath_en_a_r, clkpath_en_a_nxt;
  logic clkpath_en_b_r, clkpath_en_b_nxt;
  logic four_pin_r,     four_pin_nxt;

  // a sleeping path freezes its output; keep A awake if logic needs its clock
  // enables lag the register by one cycle, the frozen output by two
  always_comb begin
    clkpath_en_a_nxt = ~chan_b_ofs_hi_ss_r[CLKPATH_SLEEP_A_BIT];
    clkpath_en_b_nxt = ~chan_b_ofs_hi_ss_r[CLKPATH_SLEEP_B_BIT];
    four_pin_nxt     = chan_b_ofs_hi_ss_r[FOUR_PIN_SERIAL_BIT];
    dac_a_nxt        = clkpath_en_a_r ? lane_out[CHAN_A] : dac_a_r;
    dac_b_nxt        = clkpath_en_b_r ? lane_out[CHAN_B] : dac_b_r;
  end

  // output and control flops
  always_ff @(posedge core_clk) begin
    if (rst) begin
      clkpath_en_a_r <= 1'b1;
      clkpath_en_b_r <= 1'b1;
      four_pin_r     <= 1'b0;
      dac_a_r        <= '0;
      dac_b_r        <= '0;
    end else begin
      clkpath_en_a_r <= clkpath_en_a_nxt;
      clkpath_en_b_r <= clkpath_en_b_nxt;
      four_pin_r     <= four_pin_nxt;
      dac_a_r        <= dac_a_nxt;
      dac_b_r        <= dac_b_nxt;
    end
  end

  assign clkpath_en_a           = clkpath_en_a_r;
  assign clkpath_en_b           = clkpath_en_b_r;
  assign four_pin_serial_select = four_pin_r;
  assign dac_a_data             = dac_a_r;
  assign dac_b_data             = dac_b_r;

  // ****************************************************************
  // sync source selection
  // ****************************************************************
  // pulses are passed through, not stretched; a source held high stays
  // high on the output for as long as it stands
  logic multi_sync_r, multi_sync_nxt;
  logic div_sync_r,   div_sync_nxt;

  // chosen source feeds device sync always, divider sync only when enabled
  // the divider enable is a level input owned by another register slice
  always_comb begin
    multi_sync_nxt = (routing_sync_select_r[SYNC_SRC_SEL_BIT] == SYNC_SRC_FRAME)
                     ? frame_fifo_marker : external_sync_strobe;
    div_sync_nxt   = clkdiv_sync_enable & multi_sync_nxt;
  end

  // sync flops
  always_ff @(posedge core_clk) begin
    if (rst) begin
      multi_sync_r <= 1'b0;
      div_sync_r   <= 1'b0;
    end else begin
      multi_sync_r <= multi_sync_nxt;
      div_sync_r   <= div_sync_nxt;
    end
  end

  assign multi_sync_pulse  = multi_sync_r;
  assign clkdiv_sync_pulse = div_sync_r;

endmodule

`default_nettype wire
